// *** logic/asc_pkg.sv ***
// constants and types for the serial control front end of the converter
// Overview of operation
// - host sends 8-bit control word msb first; one bit taken per rising clock
// - word bits 7-4 source, 3-2 length, 1 bit order, 0 coding
// - codes 0-10 external inputs; 11 half test, 12 ref low, 13 ref high, 14 power-down
// - source select applies to the conversion right after its own cycle
// - length 00 or 10 gives 12 clocks, 11 gives 16, 01 gives 8
// - new length applies to the same cycle it is shifted in
// - conversion starts a fixed delay after the last falling edge of the frame
// - 16-clock frame sends 12 result bits then four zero pad bits msb first; lsb first sends the four pad bits first
// - 8-clock frame drops the four low bits of the result
// - length change takes effect at the sixth rising clock edge
// - sampling starts at the fourth falling clock edge
// - sampling ends and end-of-conversion drops together, a fixed delay after the last falling edge
// - data input ignored after the first eight clocks
// - order bit 0 sends msb first, 1 lsb first, from the next cycle
// - first bit shown at frame start, next bit on each falling edge
`default_nettype none
package asc_pkg;
  localparam int unsigned ASC_CLK_MHZ = 200;
  localparam int unsigned ASC_EOC_DELAY_NS = 20;
  localparam int unsigned ASC_EOC_DELAY_CYC = (ASC_EOC_DELAY_NS * ASC_CLK_MHZ + 999) / 1000;
  localparam int unsigned ASC_CONV_TIME_NS = 10000;
  localparam int unsigned ASC_CONV_CYC = ASC_CONV_TIME_NS * ASC_CLK_MHZ / 1000;
  localparam logic [7:0] ASC_WORD_RESET = 8'h00;
  localparam logic [11:0] ASC_RESULT_RESET = 12'h000;
  localparam int unsigned ASC_SRC_MSB = 7;
  localparam int unsigned ASC_SRC_LSB = 4;
  localparam int unsigned ASC_LEN_HI = 3;
  localparam int unsigned ASC_LEN_LO = 2;
  localparam int unsigned ASC_ORDER_BIT = 1;
  localparam int unsigned ASC_CODING_BIT = 0;
  localparam logic [4:0] ASC_CTRL_BITS = 5'h08;
  localparam logic [4:0] ASC_SAMPLE_EDGE = 5'h04;
  localparam logic [4:0] ASC_LEN_EDGE = 5'h06;
  localparam logic [4:0] ASC_FRAME_8 = 5'h08;
  localparam logic [4:0] ASC_FRAME_12 = 5'h0c;
  localparam logic [4:0] ASC_FRAME_16 = 5'h10;
  localparam logic [1:0] ASC_LEN_CODE_8 = 2'h1;
  localparam logic [1:0] ASC_LEN_CODE_16 = 2'h3;
  localparam logic [3:0] ASC_SRC_LAST_INPUT = 4'ha;
  localparam logic [3:0] ASC_SRC_HALF = 4'hb;
  localparam logic [3:0] ASC_SRC_REF_LO = 4'hc;
  localparam logic [3:0] ASC_SRC_REF_HI = 4'hd;
  localparam logic [3:0] ASC_SRC_POWER_DOWN = 4'he;
  typedef enum logic [1:0] {ASC_IDLE, ASC_DELAY, ASC_CONVERT} asc_state_t;
endpackage
`default_nettype wire

// *** logic/asc_frame.sv ***
// serial control front end: framing, control word, sampling, conversion handshake
`default_nettype none
module asc_frame (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic clk_en,
  // serial link pins, asynchronous to mclk
  input wire logic io_clock,
  input wire logic chip_select_n,
  input wire logic data_in,
  output logic data_out,
  output logic data_out_oe,
  output logic end_of_conversion,
  // converter core side
  input wire logic [11:0] conv_result,
  input wire logic conv_done,
  output logic [3:0] source_select,
  output logic sampling,
  output logic conv_start,
  output logic power_down,
  output logic analog_in_first,
  output logic analog_in_last,
  output logic [7:0] serial_control_word
);
  import asc_pkg::*;

  // ********************
  // synchronisers
  // ********************
  logic [1:0] clk_sync;
  logic [1:0] cs_sync;
  logic [1:0] din_sync;
  logic clk_prev;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      clk_sync <= 2'h0;
      cs_sync <= 2'h3;
      din_sync <= 2'h0;
      clk_prev <= 1'b0;
    end else if (clk_en) begin
      clk_sync <= {clk_sync[0], io_clock};
      cs_sync <= {cs_sync[0], chip_select_n};
      din_sync <= {din_sync[0], data_in};
      clk_prev <= clk_sync[1];
    end
  end
  wire selected = ~cs_sync[1];
  wire rise = selected & clk_sync[1] & ~clk_prev;
  wire fall = selected & ~clk_sync[1] & clk_prev;

  // ********************
  // frame counters and control word
  // ********************
  logic [4:0] rise_cnt;
  logic [4:0] fall_cnt;
  logic [7:0] shift_in;
  logic [1:0] len_code;
  logic order_lsb;
  logic order_next;
  logic coding;
  logic [11:0] out_word;
  logic [11:0] result_hold;
  logic [15:0] out_shift;
  asc_state_t state;
  logic [$clog2(ASC_CONV_CYC + 1)-1:0] wait_cnt;

  wire [7:0] next_shift_in = {shift_in[6:0], din_sync[1]};
  wire taking_bit = rise & (rise_cnt < ASC_CTRL_BITS);
  // the length field is complete at the sixth rising edge, then steers this frame
  wire len_arrives = rise & (rise_cnt == ASC_LEN_EDGE - 5'h01);
  wire [1:0] next_len = next_shift_in[1:0];
  wire [4:0] frame_len = (len_code == ASC_LEN_CODE_8) ? ASC_FRAME_8 :
    (len_code == ASC_LEN_CODE_16) ? ASC_FRAME_16 : ASC_FRAME_12;
  wire last_fall = fall & (fall_cnt == frame_len - 5'h01);
  wire sample_fall = fall & (fall_cnt == ASC_SAMPLE_EDGE - 5'h01);
  // only four bits have arrived at the fourth fall, so the source sits in the low nibble
  wire [3:0] word_src = shift_in[ASC_SRC_MSB - ASC_SRC_LSB:0];
  wire word_order = shift_in[ASC_ORDER_BIT];
  wire word_coding = shift_in[ASC_CODING_BIT];
  // coding flips the msb only: signed and unsigned msbs are complements
  wire [11:0] coded = {conv_result[11] ^ coding, conv_result[10:0]};
  // frame image, msb-justified; low four bits are zero padding for 16 clocks
  wire [15:0] msb_img = {result_hold, 4'h0};
  wire [15:0] rev_img;
  // lsb-first: reverse the used bits so the first one sent sits on top
  for (genvar gi = 0; gi < 16; gi++) begin : g_rev
    wire [4:0] pick = 5'h10 - frame_len + 5'(gi);
    assign rev_img[15 - gi] = (5'(gi) < frame_len) ? msb_img[pick[3:0]] : 1'b0;
  end
  // in 8-clock frames only the top byte leaves, dropping four result bits
  wire [15:0] frame_img = order_lsb ? rev_img : msb_img;
  wire src_code_dec = (word_src <= ASC_SRC_LAST_INPUT);

  // a cut frame (select released) restarts both counts from zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rise_cnt <= 5'h00;
    end else if (clk_en) begin
      if (!selected | last_fall)
        rise_cnt <= 5'h00;
      else if (rise)
        rise_cnt <= rise_cnt + 5'h01;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fall_cnt <= 5'h00;
    end else if (clk_en) begin
      if (!selected | last_fall)
        fall_cnt <= 5'h00;
      else if (fall)
        fall_cnt <= fall_cnt + 5'h01;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      shift_in <= ASC_WORD_RESET;
    end else if (clk_en & taking_bit) begin
      shift_in <= next_shift_in;
    end
  end

  // the length steers the frame it arrives in, so framing holds from start-up
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      len_code <= 2'h0;
    end else if (clk_en & len_arrives) begin
      len_code <= next_len;
    end
  end

  // ********************
  // sampling and conversion sequencing
  // ********************
  wire src_power_down = (word_src == ASC_SRC_POWER_DOWN);
  wire frame_end = (state == ASC_IDLE) & last_fall;
  wire delay_done = (state == ASC_DELAY) &
    (wait_cnt == ($bits(wait_cnt))'(ASC_EOC_DELAY_CYC - 1));
  // power-down skips the core; a timeout guards against a silent core
  wire conv_end = (state == ASC_CONVERT) &
    (power_down | conv_done | (wait_cnt == ($bits(wait_cnt))'(ASC_CONV_CYC)));

  // source choice is taken once per frame, at the fourth fall
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      source_select <= 4'h0;
      power_down <= 1'b1;
      analog_in_first <= 1'b0;
      analog_in_last <= 1'b0;
    end else if (clk_en & sample_fall) begin
      source_select <= word_src;
      power_down <= src_power_down;
      analog_in_first <= (word_src == 4'h0);
      analog_in_last <= (word_src == ASC_SRC_LAST_INPUT) & src_code_dec;
    end
  end

  // opening the switch wins over closing it: the delay end is the later event
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sampling <= 1'b0;
    end else if (clk_en) begin
      if (delay_done)
        sampling <= 1'b0;
      else if (sample_fall)
        sampling <= ~src_power_down;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      serial_control_word <= ASC_WORD_RESET;
      order_next <= 1'b0;
      coding <= 1'b0;
    end else if (clk_en & frame_end) begin
      serial_control_word <= shift_in;
      order_next <= word_order;
      coding <= word_coding;
    end
  end

  // order changes only between frames, so a frame in flight is never disturbed
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      result_hold <= ASC_RESULT_RESET;
      order_lsb <= 1'b0;
    end else if (clk_en & conv_end) begin
      if (!power_down)
        result_hold <= coded;
      order_lsb <= order_next;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= ASC_IDLE;
      wait_cnt <= '0;
      conv_start <= 1'b0;
      end_of_conversion <= 1'b1;
    end else if (clk_en) begin
      conv_start <= 1'b0;
      case (state)
        ASC_IDLE: begin
          wait_cnt <= '0;
          if (frame_end)
            state <= ASC_DELAY;
        end
        ASC_DELAY: begin
          // fixed delay keeps the sample instant jitter-free
          if (delay_done) begin
            end_of_conversion <= 1'b0;
            conv_start <= ~power_down;
            wait_cnt <= '0;
            state <= ASC_CONVERT;
          end else
            wait_cnt <= wait_cnt + 1'b1;
        end
        ASC_CONVERT: begin
          if (conv_end) begin
            end_of_conversion <= 1'b1;
            state <= ASC_IDLE;
          end else
            wait_cnt <= wait_cnt + 1'b1;
        end
        default: state <= ASC_IDLE;
      endcase
    end
  end

  // ********************
  // serial output
  // ********************
  logic load_pending;
  logic cs_prev;
  // the load waits one cycle so the freshly held result and order are in place
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      data_out_oe <= 1'b0;
      load_pending <= 1'b0;
      cs_prev <= 1'b1;
    end else if (clk_en) begin
      cs_prev <= cs_sync[1];
      data_out_oe <= selected;
      load_pending <= conv_end | (cs_prev & ~cs_sync[1]);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      out_shift <= 16'h0000;
      data_out <= 1'b0;
    end else if (clk_en) begin
      if (state != ASC_IDLE) begin
        data_out <= 1'b0;
      end else if (load_pending) begin
        out_shift <= {frame_img[14:0], 1'b0};
        data_out <= frame_img[15];
      end else if (fall & ~last_fall) begin
        out_shift <= {out_shift[14:0], 1'b0};
        data_out <= out_shift[15];
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/asc_frame_assertions.sv ***
// port assertions for the serial control front end
`default_nettype none
module asc_frame_chk import asc_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // link pins
  input wire logic chip_select_n,
  input wire logic data_out,
  input wire logic data_out_oe,
  input wire logic end_of_conversion,
  // core side
  input wire logic conv_done,
  input wire logic [3:0] source_select,
  input wire logic sampling,
  input wire logic conv_start,
  input wire logic power_down,
  input wire logic analog_in_first,
  input wire logic analog_in_last
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // two low cycles: a real conversion, not the power-down blip
  sequence s_conv; !end_of_conversion ##1 !end_of_conversion; endsequence
  sequence s_cs_idle; chip_select_n [*4]; endsequence
  a_reset_state: assert property ($fell(rst) |-> end_of_conversion && power_down)
    else $error("state after reset");
  a_start_eoc: assert property (conv_start |-> $fell(end_of_conversion) ##1 !conv_start)
    else $error("start pulse");
  a_out_quiet: assert property (s_conv |-> !data_out)
    else $error("data out while converting");
  a_no_sample: assert property (s_conv |-> !sampling)
    else $error("sampling while converting");
  a_src_hold: assert property (sampling && $past(sampling) |-> $stable(source_select))
    else $error("source moved");
  a_first_flag: assert property (analog_in_first |-> source_select == 4'h0)
    else $error("first flag");
  a_last_flag: assert property (analog_in_last |-> source_select == ASC_SRC_LAST_INPUT)
    else $error("last flag");
  a_cs_release: assert property (s_cs_idle |-> !data_out_oe)
    else $error("output enabled");
  a_eoc_return: assert property (conv_done && !end_of_conversion |-> ##[1:2] end_of_conversion)
    else $error("eoc stuck");
endmodule
bind asc_frame asc_frame_chk u_chk (.mclk(mclk), .rst(rst), .chip_select_n(chip_select_n),
  .data_out(data_out), .data_out_oe(data_out_oe), .end_of_conversion(end_of_conversion),
  .conv_done(conv_done), .source_select(source_select), .sampling(sampling),
  .conv_start(conv_start), .power_down(power_down), .analog_in_first(analog_in_first),
  .analog_in_last(analog_in_last));
`default_nettype wire

// *** tb/asc_host_model.sv ***
// host serial port model: link clock, control word, readback
`default_nettype none
module asc_host_model (
  // bench control
  input wire logic start,
  input wire logic [7:0] word,
  input wire logic [4:0] nclk,
  // link
  input wire logic data_out,
  output logic io_clock,
  output logic data_in,
  output logic busy,
  output logic [15:0] rx
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {io_clock, data_in, busy, rx} = '0;
  // clock stands low between frames; read at end of high phase for margin
  always @(posedge start) begin
    busy = 1;
    rx = '0;
    // step off the mclk edge so the pins never move on a sampling edge
    #0.5;
    for (int i = 0; i < nclk; i++) begin
      data_in = (i < 8) ? word[7 - i] : ~word[0];
      #24 io_clock = 1;
      #24 rx = {rx[14:0], data_out};
      io_clock = 0;
    end
    busy = 0;
  end
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// bench: host frames, core model, readback checks
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import asc_pkg::*;
  logic mclk = 0, rst = 1, cs_n = 1, start = 0, conv_done = 0, clk_en = 1, smp = 0;
  logic [7:0] word = '0;
  logic [4:0] nclk = '0;
  logic [11:0] conv_result = '0;
  logic io_clock, data_in, data_out, oe, eoc, sampling, conv_start, pd, a_first, a_last, busy;
  logic [3:0] src;
  logic [7:0] scw;
  logic [15:0] rx;
  logic [11:0] res [3] = '{12'ha5c, 12'h3c7, 12'h9e1};
  int failures = 0, n_tests = 0, cyc = 0, n_start = 0, busy_cnt = 0;
  always #2.5 mclk = ~mclk;
  asc_frame u_dut (.mclk(mclk), .rst(rst), .clk_en(clk_en), .io_clock(io_clock),
    .chip_select_n(cs_n), .data_in(data_in), .data_out(data_out), .data_out_oe(oe),
    .end_of_conversion(eoc), .conv_result(conv_result), .conv_done(conv_done),
    .source_select(src), .sampling(sampling), .conv_start(conv_start), .power_down(pd),
    .analog_in_first(a_first), .analog_in_last(a_last), .serial_control_word(scw));
  asc_host_model u_host (.start(start), .word(word), .nclk(nclk), .data_out(data_out),
    .io_clock(io_clock), .data_in(data_in), .busy(busy), .rx(rx));
  // ****
  // core model and timeout
  // ****
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    busy_cnt <= conv_start ? 20 : (busy_cnt > 0 ? busy_cnt - 1 : 0);
    conv_done <= (busy_cnt == 1);
    if (conv_start) n_start <= n_start + 1;
    if (busy_cnt == 1) conv_result <= res[n_start - 1];
    if (cyc == 5000) begin
      failures++;
      close_out();
    end
  end
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one frame, then wait for eoc to drop and come back
  task automatic run_frame(input logic [7:0] w, input logic [4:0] n);
    logic lo;
    lo = 0;
    smp = 0;
    @(posedge mclk);
    word <= w;
    nclk <= n;
    start <= 1;
    @(posedge mclk);
    start <= 0;
    for (int i = 0; i < 400 && (busy !== 0 || !lo || eoc !== 1); i++) begin
      @(posedge mclk);
      if (eoc === 0) lo = 1;
      if (sampling === 1) smp = 1;
    end
    cmp("eoc low", 16'h1, lo);
    cmp("eoc back", 16'h1, eoc);
  endtask
  task automatic t_twelve();
    run_frame(8'h30, ASC_FRAME_12);
    cmp("word", 16'h30, scw);
    cmp("src", 16'h3, src);
    cmp("starts", 16'h1, n_start);
    cmp("sampled", 16'h1, smp);
  endtask
  task automatic t_eight();
    run_frame(8'ha5, ASC_FRAME_8);
    cmp("rx8", {8'h0, res[0][11:4]}, rx);
    cmp("last", 16'h1, a_last);
    cmp("starts", 16'h2, n_start);
  endtask
  task automatic t_sixteen();
    run_frame(8'h0e, ASC_FRAME_16);
    cmp("rx16", {res[1] ^ 12'h800, 4'h0}, rx);
    cmp("first", 16'h1, a_first);
  endtask
  task automatic t_power_down();
    logic [11:0] r;
    r = {<<{res[2]}};
    run_frame(8'hee, ASC_FRAME_16);
    cmp("rx lsb", {4'h0, r}, rx);
    cmp("pd", 16'h1, pd);
    cmp("sampled", 16'h0, smp);
    cmp("starts", 16'h3, n_start);
  endtask
  task automatic t_deselect();
    cmp("oe on", 16'h1, oe);
    cs_n <= 1;
    repeat (6) @(posedge mclk);
    cmp("oe off", 16'h0, oe);
    clk_en <= 0;
    cs_n <= 0;
    repeat (6) @(posedge mclk);
    cmp("oe frozen", 16'h0, oe);
    clk_en <= 1;
    repeat (6) @(posedge mclk);
    cmp("oe again", 16'h1, oe);
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 0;
    repeat (6) @(posedge mclk);
    cmp("eoc rst", 16'h1, eoc);
    cs_n <= 0;
    repeat (6) @(posedge mclk);
    t_twelve();
    t_eight();
    t_sixteen();
    t_power_down();
    t_deselect();
    close_out();
  end
endmodule
`default_nettype wire
